/* logic/usb_host_cfg_defs.svh */
/*
 * Constants of the host port and host endpoint configuration block:
 * register indices, bit positions, reset values and timing.
 * Assumes a Wishbone slave with 32-bit data, one register per word.
 */
`ifndef USB_HOST_CFG_DEFS_SVH
`define USB_HOST_CFG_DEFS_SVH

// Register indices; byte address is four times the index
`define HPC_IDX        6'h01
`define HEM_IDX        6'h0D
`define RXB_IDX        6'h18
`define TXB_IDX        6'h1C
`define HAS_IDX        6'h26
`define RXT_IDX        6'h2A
`define TXT_IDX        6'h2E

// Port control fields
`define HPC_PD_DIS     7
`define HPC_DP_LVL     5
`define HPC_DM_LVL     4
`define HPC_SLOW       2
`define HPC_BUS_RST    1
`define HPC_PORT_EN    0
`define HPC_RESET      8'h80

// Endpoint mode fields
`define HEM_TX_EN      6
`define HEM_TX_DBL     4
`define HEM_RX_EN      3
`define HEM_RX_DBL     0

// Auxiliary setup fields
`define HAS_PRE_EN     7
`define HAS_SOF_EN     6

// Toggle fields
`define RXT_TOG        7
`define TXT_TOG        6

// Buffer geometry
`define BASE_BITS      15
`define BUF_HALF       15'h0040
`define BUF_NONE       15'h0000

// Frame timing
`define CLK_PERIOD_NS  10
`define SOF_PERIOD_NS  1000000
`define SOF_CYCLES     (`SOF_PERIOD_NS / `CLK_PERIOD_NS)
`define SOF_CNT_BITS   17

`endif

/* logic/usb_host_cfg_pkg.sv */
/*
 * Types of the host port configuration block: bus state and the
 * packed state record. Assumes the constants header is on the path.
 */
`include "usb_host_cfg_defs.svh"

package usb_host_cfg_pkg;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'h0,
        BUS_ACK  = 2'h1
    } bus_state_t;

    typedef struct packed {
        bus_state_t                  bus;
        logic                        ack;
        logic [31:0]                 rdat;
        logic                        pd_dis;
        logic                        slow;
        logic                        bus_rst;
        logic                        port_en;
        logic                        tx_en;
        logic                        tx_dbl;
        logic                        rx_en;
        logic                        rx_dbl;
        logic [15:0]                 rx_base;
        logic [15:0]                 tx_base;
        logic                        pre_en;
        logic                        sof_en;
        logic                        tx_tog;
        logic                        rx_tog;
        logic                        dp_s1;
        logic                        dp_s2;
        logic                        dm_s1;
        logic                        dm_s2;
        logic                        dis_s1;
        logic                        dis_s2;
        logic [`SOF_CNT_BITS-1:0]    sof_cnt;
        logic                        sof_pulse;
        logic                        tx_grant;
        logic                        rx_grant;
        logic [`BASE_BITS-1:0]       tx_addr;
        logic [`BASE_BITS-1:0]       rx_addr;
        logic                        pulldown_on;
        logic                        line_oe;
    } cfg_state_t;

endpackage

/* logic/usb_host_port_endpoint_cfg.sv */
/*
 * Host port and host endpoint configuration for a USB host: port
 * control, line level readback, endpoint enables, buffer addressing,
 * data toggles, preamble and automatic frame start timing.
 * Assumes a classic Wishbone master on clk_sys, a serial engine on the
 * same clock issuing tx/rx requests, and asynchronous line pins.
 */
// The Wishbone register port and the address map were left to the implementer.
// Contract
// [R1] Pull-down bit 1 disables line pull-downs, 0 enables them; resets to 1.
// [R2] Pull-downs follow the bit regardless of port or GPIO use.
// [R3] Bit 5 reads D+ level, bit 4 reads D- level, 1 is high.
// [R4] Slow select 1 means low speed 1.5Mbps, 0 full speed 12Mbps.
// [R5] Bus reset is driven on the lines while the bus reset bit is 1.
// [R6] Port enable works while 1 and clears itself on disconnect.
// [R7] SETUP/OUT transmission only while transmit enable is set.
// [R8] IN data accepted only while receive enable is set.
// [R9] Single transmit mode uses one 64-byte buffer at transmit base.
// [R10] Double transmit mode picks 64-byte half by transmit toggle.
// [R11] Single receive mode uses one 64-byte buffer at receive base.
// [R12] Double receive mode picks 64-byte half by expected receive toggle.
// [R13] Receive base uses lower 15 bits; software keeps it 4-byte aligned.
// [R14] Transmit base uses lower 15 bits; software keeps it 4-byte aligned.
// [R15] Preamble enable 1 sends PRE before low-speed traffic via hub.
// [R16] Frame-start enable 1 issues SOF automatically, 0 issues none; code issues SOF only at full speed, port enabled, outside bus reset.
// [R17] Transmit toggle 1 sends DATA1, 0 sends DATA0.
// [R18] Receive toggle 1 expects DATA1, 0 expects DATA0.
// [R19] Automatic SOF at full speed is spaced one millisecond apart.
`timescale 1ns/1ns
`default_nettype none

module usb_host_port_endpoint_cfg
    import usb_host_cfg_pkg::*;
#(
    parameter int unsigned SOF_PERIOD_CYCLES = `SOF_CYCLES
) (
    // Clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  sys_rst,
    // Wishbone slave
    input  wire logic                  wb_cyc_i,
    input  wire logic                  wb_stb_i,
    input  wire logic                  wb_we_i,
    input  wire logic [7:0]            wb_adr_i,
    input  wire logic [3:0]            wb_sel_i,
    input  wire logic [31:0]           wb_dat_i,
    output var  logic [31:0]           wb_dat_o,
    output var  logic                  wb_ack_o,
    // Line pins
    input  wire logic                  dplus_in,
    output var  logic                  dplus_out,
    output var  logic                  dplus_oe,
    input  wire logic                  dminus_in,
    output var  logic                  dminus_out,
    output var  logic                  dminus_oe,
    output var  logic                  line_pulldown_on,
    input  wire logic                  dev_detached,
    // Port state to the serial engine
    output var  logic                  host_port_enable,
    output var  logic                  slow_rate_select,
    output var  logic                  bus_reset_force,
    output var  logic                  preamble_enable,
    output var  logic                  sof_strobe,
    // Endpoint requests from the serial engine
    input  wire logic                  tx_request,
    input  wire logic                  rx_request,
    output var  logic                  tx_grant,
    output var  logic                  rx_grant,
    // Endpoint buffer addressing and toggles
    output var  logic                  tx_buf_active,
    output var  logic [`BASE_BITS-1:0] tx_buf_addr,
    output var  logic                  rx_buf_active,
    output var  logic [`BASE_BITS-1:0] rx_buf_addr,
    output var  logic                  tx_data_toggle,
    output var  logic                  rx_expected_toggle
);

    localparam logic [`SOF_CNT_BITS-1:0] SOF_LAST =
        `SOF_CNT_BITS'(SOF_PERIOD_CYCLES - 1);

    cfg_state_t st_q;
    cfg_state_t st_d;

    function automatic logic reg_hit(input logic [7:0] adr, input logic [5:0] idx);
        reg_hit = (adr[7:2] == idx) && (adr[1:0] == 2'h0);
    endfunction

    function automatic logic [31:0] read_mux(input logic [7:0] adr, input cfg_state_t s);
        read_mux = 32'h0000_0000;
        if (reg_hit(adr, `HPC_IDX)) begin
            read_mux[`HPC_PD_DIS]  = s.pd_dis;
            read_mux[`HPC_DP_LVL]  = s.dp_s2;  // see [R3]
            read_mux[`HPC_DM_LVL]  = s.dm_s2;  // see [R3]
            read_mux[`HPC_SLOW]    = s.slow;
            read_mux[`HPC_BUS_RST] = s.bus_rst;
            read_mux[`HPC_PORT_EN] = s.port_en;
        end else if (reg_hit(adr, `HEM_IDX)) begin
            read_mux[`HEM_TX_EN]  = s.tx_en;
            read_mux[`HEM_TX_DBL] = s.tx_dbl;
            read_mux[`HEM_RX_EN]  = s.rx_en;
            read_mux[`HEM_RX_DBL] = s.rx_dbl;
        end else if (reg_hit(adr, `RXB_IDX)) begin
            read_mux[15:0] = s.rx_base;
        end else if (reg_hit(adr, `TXB_IDX)) begin
            read_mux[15:0] = s.tx_base;
        end else if (reg_hit(adr, `HAS_IDX)) begin
            read_mux[`HAS_PRE_EN] = s.pre_en;
            read_mux[`HAS_SOF_EN] = s.sof_en;
        end else if (reg_hit(adr, `RXT_IDX)) begin
            read_mux[`RXT_TOG] = s.rx_tog;
        end else if (reg_hit(adr, `TXT_IDX)) begin
            read_mux[`TXT_TOG] = s.tx_tog;
        end
    endfunction

    always_comb begin
        st_d = st_q;
        // Two-flop synchronisers for pins
        st_d.dp_s1  = dplus_in;
        st_d.dp_s2  = st_q.dp_s1;
        st_d.dm_s1  = dminus_in;
        st_d.dm_s2  = st_q.dm_s1;
        st_d.dis_s1 = dev_detached;
        st_d.dis_s2 = st_q.dis_s1;

        // Bus slave: answer one cycle after the request, write on the ack edge
        st_d.ack = 1'b0;
        case (st_q.bus)
            BUS_IDLE: begin
                if (wb_cyc_i && wb_stb_i) begin
                    st_d.bus  = BUS_ACK;
                    st_d.ack  = 1'b1;
                    st_d.rdat = wb_we_i ? 32'h0000_0000 : read_mux(wb_adr_i, st_q);
                end
            end
            BUS_ACK: begin
                st_d.bus = BUS_IDLE;
                if (wb_cyc_i && wb_stb_i && wb_we_i) begin
                    if (reg_hit(wb_adr_i, `HPC_IDX) && wb_sel_i[0]) begin
                        st_d.pd_dis  = wb_dat_i[`HPC_PD_DIS];   // see [R1]
                        st_d.slow    = wb_dat_i[`HPC_SLOW];     // see [R4]
                        st_d.bus_rst = wb_dat_i[`HPC_BUS_RST];  // see [R5]
                        st_d.port_en = wb_dat_i[`HPC_PORT_EN];  // see [R6]
                    end else if (reg_hit(wb_adr_i, `HEM_IDX) && wb_sel_i[0]) begin
                        st_d.tx_en  = wb_dat_i[`HEM_TX_EN];
                        st_d.tx_dbl = wb_dat_i[`HEM_TX_DBL];
                        st_d.rx_en  = wb_dat_i[`HEM_RX_EN];
                        st_d.rx_dbl = wb_dat_i[`HEM_RX_DBL];
                    end else if (reg_hit(wb_adr_i, `RXB_IDX)) begin
                        if (wb_sel_i[0]) begin
                            st_d.rx_base[7:0] = wb_dat_i[7:0];
                        end
                        if (wb_sel_i[1]) begin
                            st_d.rx_base[15:8] = wb_dat_i[15:8];
                        end
                    end else if (reg_hit(wb_adr_i, `TXB_IDX)) begin
                        if (wb_sel_i[0]) begin
                            st_d.tx_base[7:0] = wb_dat_i[7:0];
                        end
                        if (wb_sel_i[1]) begin
                            st_d.tx_base[15:8] = wb_dat_i[15:8];
                        end
                    end else if (reg_hit(wb_adr_i, `HAS_IDX) && wb_sel_i[0]) begin
                        st_d.pre_en = wb_dat_i[`HAS_PRE_EN];
                        st_d.sof_en = wb_dat_i[`HAS_SOF_EN];
                    end else if (reg_hit(wb_adr_i, `RXT_IDX) && wb_sel_i[0]) begin
                        st_d.rx_tog = wb_dat_i[`RXT_TOG];
                    end else if (reg_hit(wb_adr_i, `TXT_IDX) && wb_sel_i[0]) begin
                        st_d.tx_tog = wb_dat_i[`TXT_TOG];
                    end
                end
            end
            default: begin
                st_d.bus = BUS_IDLE;
            end
        endcase

        // Detach clears the port, winning over a same-cycle write
        if (st_q.dis_s2) begin
            st_d.port_en = 1'b0;  // see [R6]
        end

        // Pull-downs follow the bit alone, port state ignored
        st_d.pulldown_on = ~st_d.pd_dis;  // see [R1] see [R2]
        // Bus reset drives SE0 on both lines
        st_d.line_oe = st_d.bus_rst;      // see [R5]

        // Buffer address: upper half only in double mode with toggle set
        st_d.tx_addr = st_d.tx_base[`BASE_BITS-1:0]
                     + ((st_d.tx_dbl && st_d.tx_tog) ? `BUF_HALF : `BUF_NONE);  // see [R9] see [R10] see [R14]
        st_d.rx_addr = st_d.rx_base[`BASE_BITS-1:0]
                     + ((st_d.rx_dbl && st_d.rx_tog) ? `BUF_HALF : `BUF_NONE);  // see [R11] see [R12] see [R13]

        // Engine requests pass only with endpoint and port enabled
        st_d.tx_grant = tx_request && st_q.tx_en && st_q.port_en;  // see [R7]
        st_d.rx_grant = rx_request && st_q.rx_en && st_q.port_en;  // see [R8]

        // Frame start timer, full speed only, idle during bus reset
        st_d.sof_pulse = 1'b0;
        if (st_q.sof_en && st_q.port_en && !st_q.bus_rst && !st_q.slow) begin  // see [R16]
            if (st_q.sof_cnt == SOF_LAST) begin
                st_d.sof_cnt   = '0;
                st_d.sof_pulse = 1'b1;  // see [R19]
            end else begin
                st_d.sof_cnt = st_q.sof_cnt + `SOF_CNT_BITS'(1);
            end
        end else begin
            st_d.sof_cnt = '0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            st_q             <= '0;
            st_q.bus         <= BUS_IDLE;
            st_q.pd_dis      <= 1'(`HPC_RESET >> `HPC_PD_DIS);  // see [R1]
            st_q.pulldown_on <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    assign wb_dat_o           = st_q.rdat;
    assign wb_ack_o           = st_q.ack;
    assign dplus_out          = 1'b0;
    assign dminus_out         = 1'b0;
    assign dplus_oe           = st_q.line_oe;
    assign dminus_oe          = st_q.line_oe;
    assign line_pulldown_on   = st_q.pulldown_on;
    assign host_port_enable   = st_q.port_en;
    assign slow_rate_select   = st_q.slow;      // see [R4]
    assign bus_reset_force    = st_q.bus_rst;
    assign preamble_enable    = st_q.pre_en;    // see [R15]
    assign sof_strobe         = st_q.sof_pulse;
    assign tx_grant           = st_q.tx_grant;
    assign rx_grant           = st_q.rx_grant;
    assign tx_buf_active      = st_q.tx_en;     // see [R7]
    assign tx_buf_addr        = st_q.tx_addr;
    assign rx_buf_active      = st_q.rx_en;     // see [R8]
    assign rx_buf_addr        = st_q.rx_addr;
    assign tx_data_toggle     = st_q.tx_tog;    // see [R17]
    assign rx_expected_toggle = st_q.rx_tog;    // see [R18]

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    property p_pulldown_write;  // see [R1]
        (st_q.bus == BUS_ACK && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0]
            && reg_hit(wb_adr_i, `HPC_IDX))
            |=> (line_pulldown_on == !$past(wb_dat_i[`HPC_PD_DIS]));
    endproperty
    a_pulldown_write: assert property (p_pulldown_write)  // see [R1]
        else $error("pull-down mismatch");

    property p_level_read;  // see [R3]
        (st_q.bus == BUS_IDLE && wb_cyc_i && wb_stb_i && !wb_we_i
            && reg_hit(wb_adr_i, `HPC_IDX))
            |=> wb_ack_o && wb_dat_o[`HPC_DP_LVL] == $past(st_q.dp_s2)
                && wb_dat_o[`HPC_DM_LVL] == $past(st_q.dm_s2);
    endproperty
    a_level_read: assert property (p_level_read)  // see [R3]
        else $error("line level readback wrong");

    property p_detach_clear;  // see [R6]
        st_q.dis_s2 |=> !host_port_enable;
    endproperty
    a_detach_clear: assert property (p_detach_clear)  // see [R6]
        else $error("port stays enabled on detach");

    property p_reset_drive;  // see [R5]
        bus_reset_force |-> (dplus_oe && dminus_oe && !dplus_out && !dminus_out);
    endproperty
    a_reset_drive: assert property (p_reset_drive)  // see [R5]
        else $error("bus reset not driven");

    property p_tx_gate;  // see [R7]
        tx_grant |-> $past(tx_request) && $past(st_q.tx_en) && $past(host_port_enable);
    endproperty
    a_tx_gate: assert property (p_tx_gate)  // see [R7]
        else $error("tx granted while disabled");

    property p_rx_gate;  // see [R8]
        $rose(rx_grant) |-> $past(rx_request) && $past(rx_buf_active);
    endproperty
    a_rx_gate: assert property (p_rx_gate)  // see [R8]
        else $error("rx granted while disabled");

    property p_tx_half;  // see [R10]
        (tx_data_toggle && st_q.tx_dbl) ##1 (tx_data_toggle && st_q.tx_dbl
            && $stable(st_q.tx_base))
            |-> tx_buf_addr == st_q.tx_base[`BASE_BITS-1:0] + `BUF_HALF;
    endproperty
    a_tx_half: assert property (p_tx_half)  // see [R10]
        else $error("tx half select wrong");

    property p_rx_single;  // see [R11]
        (!st_q.rx_dbl && $stable(st_q.rx_base)) [*2]
            |-> rx_buf_addr == st_q.rx_base[`BASE_BITS-1:0];
    endproperty
    a_rx_single: assert property (p_rx_single)  // see [R11]
        else $error("rx single buffer address wrong");

    property p_sof_spacing;  // see [R19]
        sof_strobe |-> $past(st_q.sof_cnt) == SOF_LAST && !$past(sof_strobe);
    endproperty
    a_sof_spacing: assert property (p_sof_spacing)  // see [R19]
        else $error("frame start spacing wrong");

    property p_sof_gate;  // see [R16]
        sof_strobe |-> $past(st_q.sof_en) && !$past(slow_rate_select);
    endproperty
    a_sof_gate: assert property (p_sof_gate)  // see [R16]
        else $error("frame start while disabled");

    // Write taken at this edge, for the checks below
    logic wr_take;
    assign wr_take = (st_q.bus == BUS_ACK) && wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0];

    property p_slow_write;  // see [R4]
        wr_take && reg_hit(wb_adr_i, `HPC_IDX)
            |=> slow_rate_select == $past(wb_dat_i[`HPC_SLOW]);
    endproperty
    a_slow_write: assert property (p_slow_write)  // see [R4]
        else $error("speed select write lost");

    property p_bus_rst_write;  // see [R5]
        wr_take && reg_hit(wb_adr_i, `HPC_IDX)
            |=> bus_reset_force == $past(wb_dat_i[`HPC_BUS_RST]);
    endproperty
    a_bus_rst_write: assert property (p_bus_rst_write)  // see [R5]
        else $error("bus reset write lost");

    property p_port_write;  // see [R6]
        wr_take && reg_hit(wb_adr_i, `HPC_IDX) && !st_q.dis_s2
            |=> host_port_enable == $past(wb_dat_i[`HPC_PORT_EN]);
    endproperty
    a_port_write: assert property (p_port_write)  // see [R6]
        else $error("port enable write lost");

    property p_rx_enable_gate;  // see [R8]
        rx_grant |-> $past(rx_request) && $past(st_q.rx_en) && $past(host_port_enable);
    endproperty
    a_rx_enable_gate: assert property (p_rx_enable_gate)  // see [R8]
        else $error("rx grant without enables");

    property p_tx_single;  // see [R9]
        (!st_q.tx_dbl && $stable(st_q.tx_base)) [*2]
            |-> tx_buf_addr == st_q.tx_base[`BASE_BITS-1:0];
    endproperty
    a_tx_single: assert property (p_tx_single)  // see [R9]
        else $error("tx single buffer address wrong");

    property p_rx_half;  // see [R12]
        (rx_expected_toggle && st_q.rx_dbl && $stable(st_q.rx_base)) [*2]
            |-> rx_buf_addr == st_q.rx_base[`BASE_BITS-1:0] + `BUF_HALF;
    endproperty
    a_rx_half: assert property (p_rx_half)  // see [R12]
        else $error("rx half select wrong");

    property p_preamble_write;  // see [R15]
        wr_take && reg_hit(wb_adr_i, `HAS_IDX)
            |=> preamble_enable == $past(wb_dat_i[`HAS_PRE_EN]);
    endproperty
    a_preamble_write: assert property (p_preamble_write)  // see [R15]
        else $error("preamble write lost");

    property p_tx_toggle_write;  // see [R17]
        wr_take && reg_hit(wb_adr_i, `TXT_IDX)
            |=> tx_data_toggle == $past(wb_dat_i[`TXT_TOG]);
    endproperty
    a_tx_toggle_write: assert property (p_tx_toggle_write)  // see [R17]
        else $error("tx toggle write lost");

    property p_rx_toggle_write;  // see [R18]
        wr_take && reg_hit(wb_adr_i, `RXT_IDX)
            |=> rx_expected_toggle == $past(wb_dat_i[`RXT_TOG]);
    endproperty
    a_rx_toggle_write: assert property (p_rx_toggle_write)  // see [R18]
        else $error("rx toggle write lost");

endmodule // usb_host_port_endpoint_cfg

`default_nettype wire

/* test/usb_dev_model.sv */
/*
 * Attached device on the host port lines: idles in a chosen line state,
 * can be unplugged. Assumes the block drives SE0 only while its enables are up.
 */
`timescale 1ns/1ns
`default_nettype none

module usb_dev_model (
    // Block side
    input  wire logic clk_sys,
    input  wire logic dplus_out,
    input  wire logic dplus_oe,
    input  wire logic dminus_out,
    input  wire logic dminus_oe,
    input  wire logic line_pulldown_on,
    // Bench control
    input  wire logic attach,
    input  wire logic dp_lvl,
    input  wire logic dm_lvl,
    // Line levels
    output var  logic dplus_in,
    output var  logic dminus_in,
    output var  logic dev_detached
);
    logic flt_q = 1'b0;

    // Undriven line with pull-downs off floats: show a changing value
    always @(posedge clk_sys) flt_q <= ~flt_q;

    always_comb begin
        dev_detached = ~attach;
        dplus_in     = dplus_oe ? dplus_out : attach ? dp_lvl :
                       line_pulldown_on ? 1'b0 : flt_q;
        dminus_in    = dminus_oe ? dminus_out : attach ? dm_lvl :
                       line_pulldown_on ? 1'b0 : ~flt_q;
    end
endmodule // usb_dev_model

`default_nettype wire

/* test/tb.sv */
/*
 * Self-checking bench of the host port configuration block.
 * Assumes the constants header is on the include path.
 */
`timescale 1ns/1ns
`default_nettype none
`include "usb_host_cfg_defs.svh"
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; \
    $display("BAD t=%0t got %h exp %h", $time, (a), (b)); end end

module tb;
    import usb_host_cfg_pkg::*;
    localparam logic [7:0] A_HPC = {`HPC_IDX, 2'b00};
    localparam logic [7:0] A_HEM = {`HEM_IDX, 2'b00};
    localparam logic [7:0] A_RXB = {`RXB_IDX, 2'b00};
    localparam logic [7:0] A_TXB = {`TXB_IDX, 2'b00};
    localparam logic [7:0] A_HAS = {`HAS_IDX, 2'b00};
    localparam logic [7:0] A_RXT = {`RXT_IDX, 2'b00};
    localparam logic [7:0] A_TXT = {`TXT_IDX, 2'b00};
    logic clk_sys = 0, sys_rst = 1, cyc = 0, stb = 0, we = 0;
    logic [7:0] adr = 0;
    logic [3:0] sel = 0;
    logic [31:0] wdat = 0, rdat, q;
    logic dp_i, dm_i, dp_o, dm_o, dp_oe, dm_oe, pd_on, det, attach = 1, dp_l = 0, dm_l = 0;
    logic pen, slow, brst, pre, sof, txr = 1, rxr = 1, txg, rxg, txa, rxa, ttog, rtog;
    logic [14:0] txad, rxad;
    logic ack;
    int n_errors = 0, cmp_count = 0, cyc_cnt = 0;

    always #5 clk_sys = ~clk_sys;

    usb_host_port_endpoint_cfg #(.SOF_PERIOD_CYCLES(16)) dut (
        .clk_sys(clk_sys), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .dplus_in(dp_i), .dplus_out(dp_o), .dplus_oe(dp_oe), .dminus_in(dm_i),
        .dminus_out(dm_o), .dminus_oe(dm_oe), .line_pulldown_on(pd_on), .dev_detached(det),
        .host_port_enable(pen), .slow_rate_select(slow), .bus_reset_force(brst),
        .preamble_enable(pre), .sof_strobe(sof), .tx_request(txr), .rx_request(rxr),
        .tx_grant(txg), .rx_grant(rxg), .tx_buf_active(txa), .tx_buf_addr(txad),
        .rx_buf_active(rxa), .rx_buf_addr(rxad), .tx_data_toggle(ttog),
        .rx_expected_toggle(rtog));

    usb_dev_model dev (
        .clk_sys(clk_sys), .dplus_out(dp_o), .dplus_oe(dp_oe), .dminus_out(dm_o),
        .dminus_oe(dm_oe), .line_pulldown_on(pd_on), .attach(attach), .dp_lvl(dp_l),
        .dm_lvl(dm_l), .dplus_in(dp_i), .dminus_in(dm_i), .dev_detached(det));

    task automatic final_report();
        if (n_errors == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cyc_cnt++;
        if (cyc_cnt == 20000) begin
            n_errors++;
            final_report();
        end
    end

    // One classic cycle: held until ack is seen at a rising edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
        @(posedge clk_sys);
        cyc <= 1; stb <= 1; we <= w; adr <= a; sel <= 4'hF; wdat <= d;
        do @(posedge clk_sys); while (ack !== 1'b1);
        r = rdat;
        cyc <= 0; stb <= 0; we <= 0;
        @(negedge clk_sys);
        `CHK(ack, 1'b0)
    endtask

    task automatic t_reset();
        wb(0, A_HPC, 0, q); `CHK(q, 32'h0000_0080)
        `CHK(pd_on, 1'b0)
        wb(0, A_HEM, 0, q); `CHK(q, 32'h0000_0000)
        wb(0, A_HAS, 0, q); `CHK(q, 32'h0000_0000)
        wb(0, A_TXT, 0, q); `CHK(q, 32'h0000_0000)
    endtask

    task automatic t_port();
        wb(1, A_HPC, 32'h0000_0000, q); `CHK(pd_on, 1'b1)
        wb(1, A_HPC, 32'h0000_0080, q); `CHK(pd_on, 1'b0)
        @(posedge clk_sys);
        dp_l <= 1;
        repeat (5) @(negedge clk_sys);
        wb(0, A_HPC, 0, q); `CHK(q, 32'h0000_00A0)
        @(posedge clk_sys);
        dp_l <= 0;
        dm_l <= 1;
        repeat (5) @(negedge clk_sys);
        wb(0, A_HPC, 0, q); `CHK(q, 32'h0000_0090)
        wb(1, A_HPC, 32'h0000_00FB, q);
        `CHK({brst, dp_oe, dm_oe, dp_o, dm_o}, 5'b11100)
        repeat (5) @(negedge clk_sys);
        wb(0, A_HPC, 0, q); `CHK(q, 32'h0000_0083)
        wb(1, A_HPC, 32'h0000_0084, q);
        `CHK({slow, brst, dp_oe, pen}, 4'b1000)
        wb(1, A_HPC, 32'h0000_0080, q); `CHK(slow, 1'b0)
        @(posedge clk_sys);
        dm_l <= 0;
    endtask

    task automatic t_detach();
        wb(1, A_HPC, 32'h0000_0081, q); `CHK(pen, 1'b1)
        @(posedge clk_sys);
        attach <= 0;
        repeat (6) @(negedge clk_sys);
        `CHK(pen, 1'b0)
        wb(0, A_HPC, 0, q); `CHK(q[0], 1'b0)
        @(posedge clk_sys);
        attach <= 1;
        repeat (4) @(posedge clk_sys);
    endtask

    task automatic t_endpoints();
        logic dbl, tog;
        logic [7:0] m;
        logic [14:0] off;
        wb(1, A_HPC, 32'h0000_0081, q);
        wb(1, A_TXB, 32'h0000_1234, q);
        wb(1, A_RXB, 32'h0000_8F00, q);
        @(negedge clk_sys);
        `CHK({txg, rxg, txa, rxa}, 4'b0000)
        for (int i = 0; i < 4; i++) begin
            dbl = i[1];
            tog = i[0];
            m = 8'h48 | {3'b000, dbl, 3'b000, dbl};
            off = (dbl & tog) ? `BUF_HALF : `BUF_NONE;
            wb(1, A_HEM, {24'hFFFF_FF, 8'hA6 | m}, q);
            wb(1, A_TXT, {25'h0, tog, 6'h0}, q);
            wb(1, A_RXT, {24'h0, tog, 7'h0}, q);
            wb(0, A_HEM, 0, q); `CHK(q, {24'h0, m})
            `CHK({txg, rxg, txa, rxa}, 4'b1111)
            `CHK({ttog, rtog}, {tog, tog})
            `CHK(txad, 15'h1234 + off)
            `CHK(rxad, 15'h0F00 + off)
        end
        @(posedge clk_sys);
        txr <= 0;
        repeat (3) @(negedge clk_sys);
        `CHK({txg, rxg}, 2'b01)
        @(posedge clk_sys);
        txr <= 1;
        wb(1, A_HEM, 32'h0000_0000, q);
        @(negedge clk_sys);
        `CHK({txg, rxg, txa, rxa}, 4'b0000)
    endtask

    task automatic t_frames();
        int n;
        wb(1, A_HAS, 32'h0000_0040, q);
        n = 0;
        while (sof !== 1'b1 && n < 40) begin @(negedge clk_sys); n++; end
        `CHK(sof, 1'b1)
        n = 0;
        do begin @(negedge clk_sys); n++; end while (sof !== 1'b1 && n < 40);
        `CHK(n, 16)
        wb(1, A_HAS, 32'h0000_0080, q);
        `CHK(pre, 1'b1)
        n = 0;
        repeat (40) begin @(negedge clk_sys); n += (sof === 1'b1); end
        `CHK(n, 0)
        wb(1, A_HAS, 32'h0000_0000, q); `CHK(pre, 1'b0)
    endtask

    task automatic t_unmapped();
        wb(1, 8'hFC, 32'hFFFF_FFFF, q);
        wb(0, 8'hFC, 0, q); `CHK(q, 32'h0000_0000)
        wb(0, A_HPC, 0, q); `CHK(q, 32'h0000_0081)
    endtask

    initial begin
        repeat (8) @(posedge clk_sys);
        sys_rst <= 0;
        t_reset();
        t_port();
        t_detach();
        t_endpoints();
        t_frames();
        t_unmapped();
        final_report();
    end
endmodule // tb

`default_nettype wire
